// [pqa_auto_tx_framer.sv]
`timescale 1ns/100ps
`include "pqa_map.svh"
module pqa_auto_tx_framer
    import pqa_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // register port
    input  wire pqa_bus_t    bus,
    output logic [7:0]       rdData,
    // air side
    input  wire logic        rxPin,
    output logic             txPin,
    output logic             txEnable,
    // modem settings
    output pqa_modem_t       modem,
    // interrupt
    output logic             irq
);
    pqa_top_t   s;
    pqa_top_t   next_s;
    logic       validPulse;
    logic       invalidPulse;
    logic [6:0] fill;

    function automatic logic isModem(input logic [7:0] a);
        isModem = (a >= `PQA_ADDR_MODEM_LO) && (a <= `PQA_ADDR_MODEM_HI);
    endfunction

    pqa_preamble_qualifier u_qualifier (
        .clock        (clock),
        .rst_b        (rst_b),
        .bitTick      (s.bitTick),
        .rxLevel      (s.rxLevel),
        .rxOn         (s.opctl1[`PQA_BIT_RXON]),
        .threshold    (s.pthr[7:3]),
        .validPulse   (validPulse),
        .invalidPulse (invalidPulse)
    );

    assign fill = 7'(s.wrPtr - s.rdPtr);

    always_comb
    begin
        next_s = s;
        next_s.rdData = 8'h00;
        next_s.bitTick = 1'b0;

        // receive pin: three stages, change taken when last two agree
        next_s.sync = {s.sync[1:0], rxPin};
        if (s.sync[1] == s.sync[2])
            next_s.rxLevel = s.sync[2];

        // bit time from the programmed rate, in clock cycles per bit
        if (s.bitCnt == 16'h0000)
        begin
            next_s.bitTick = 1'b1;
            next_s.bitCnt = (s.rate > 16'h0001) ?
                16'(s.rate - 16'h0001) : 16'h0000;
        end
        else
        begin
            next_s.bitCnt = 16'(s.bitCnt - 16'h0001);
        end

        // register writes
        if (bus.wr)
        begin
            case (bus.addr)
                `PQA_ADDR_MASK1:
                    next_s.mask1 = bus.wrData;
                `PQA_ADDR_MASK2:
                    next_s.mask2 = bus.wrData;
                `PQA_ADDR_OPCTL1:
                    next_s.opctl1 = bus.wrData;
                `PQA_ADDR_OPCTL2:
                begin
                    next_s.opctl2 = bus.wrData;
                    next_s.opctl2[`PQA_BIT_TXCLR] = 1'b0;
                    if (bus.wrData[`PQA_BIT_TXCLR])
                    begin
                        next_s.wrPtr = 7'h00;
                        next_s.rdPtr = 7'h00;
                        next_s.startPtr = 7'h00;
                        next_s.newLoaded = 1'b0;
                        next_s.canResend = 1'b0;
                    end
                end
                `PQA_ADDR_FILT:
                    next_s.filt = bus.wrData;
                `PQA_ADDR_PTHR:
                    next_s.pthr = bus.wrData;
                `PQA_ADDR_RATE_HI:
                    next_s.rate[15:8] = bus.wrData;
                `PQA_ADDR_RATE_LO:
                    next_s.rate[7:0] = bus.wrData;
                `PQA_ADDR_AFULL:
                    next_s.afull = bus.wrData[6:0];
                `PQA_ADDR_FIFO:
                begin
                    // writes to a full FIFO are dropped
                    if (fill != `PQA_FIFO_FULL)
                    begin
                        next_s.mem[s.wrPtr[5:0]] = bus.wrData;
                        next_s.wrPtr = 7'(s.wrPtr + 7'h01);
                        next_s.newLoaded = 1'b1;
                        // streamed packet no longer held whole
                        if (s.txSt == PQA_TX)
                            next_s.canResend = 1'b0;
                    end
                end
                default:
                begin
                    if (isModem(bus.addr))
                        next_s.modemRegs[3'(bus.addr -
                            `PQA_ADDR_MODEM_LO)] = bus.wrData;
                end
            endcase
        end

        // register reads, data shown in the following cycle
        if (bus.rd)
        begin
            case (bus.addr)
                `PQA_ADDR_STAT1:
                begin
                    next_s.rdData = s.stat1;
                    next_s.stat1 = 8'h00;
                end
                `PQA_ADDR_STAT2:
                begin
                    next_s.rdData = s.stat2;
                    next_s.stat2 = 8'h00;
                end
                `PQA_ADDR_MASK1:
                    next_s.rdData = s.mask1;
                `PQA_ADDR_MASK2:
                    next_s.rdData = s.mask2;
                `PQA_ADDR_OPCTL1:
                    next_s.rdData = s.opctl1;
                `PQA_ADDR_OPCTL2:
                    next_s.rdData = s.opctl2;
                `PQA_ADDR_FILT:
                    next_s.rdData = s.filt;
                `PQA_ADDR_PTHR:
                    next_s.rdData = s.pthr;
                `PQA_ADDR_RATE_HI:
                    next_s.rdData = s.rate[15:8];
                `PQA_ADDR_RATE_LO:
                    next_s.rdData = s.rate[7:0];
                `PQA_ADDR_AFULL:
                    next_s.rdData = {1'b0, s.afull};
                default:
                begin
                    if (isModem(bus.addr))
                        next_s.rdData = s.modemRegs[3'(bus.addr -
                            `PQA_ADDR_MODEM_LO)];
                end
            endcase
        end

        // detector events, set wins over the read clear
        if (invalidPulse)
            next_s.stat2[`PQA_BIT_INVALID] = 1'b1;
        if (validPulse)
            next_s.stat2[`PQA_BIT_VALID] = 1'b1;

        // transmit sequencer
        case (s.txSt)
            PQA_IDLE:
            begin
                if (s.opctl1[`PQA_BIT_TXREQ] ||
                    (s.opctl2[`PQA_BIT_AUTOTX] && fill >= s.afull))
                begin
                    next_s.txSt = PQA_TX;
                    next_s.txEnable = 1'b1;
                    next_s.bitIdx = 3'h0;
                    next_s.stat1[`PQA_BIT_TXSTART] = 1'b1;
                    if (s.opctl1[`PQA_BIT_TXREQ] && !s.newLoaded &&
                        s.canResend)
                        next_s.rdPtr = s.startPtr;
                    else
                        next_s.startPtr = s.rdPtr;
                    next_s.newLoaded = 1'b0;
                    next_s.canResend = 1'b1;
                end
            end
            PQA_TX:
            begin
                if (s.bitTick)
                begin
                    if (s.bitIdx != 3'h0)
                    begin
                        next_s.txPin = s.shift[7];
                        next_s.shift = {s.shift[6:0], 1'b0};
                        next_s.bitIdx = 3'(s.bitIdx - 3'h1);
                    end
                    else if (s.rdPtr == s.wrPtr)
                    begin
                        // FIFO drained: back to idle
                        next_s.txSt = PQA_IDLE;
                        next_s.txEnable = 1'b0;
                        next_s.txPin = 1'b0;
                        next_s.opctl1[`PQA_BIT_TXREQ] = 1'b0;
                        next_s.stat1[`PQA_BIT_TXDONE] = 1'b1;
                    end
                    else
                    begin
                        next_s.txPin = s.mem[s.rdPtr[5:0]][7];
                        next_s.shift = {s.mem[s.rdPtr[5:0]][6:0], 1'b0};
                        next_s.rdPtr = 7'(s.rdPtr + 7'h01);
                        next_s.bitIdx = 3'h7;
                    end
                end
            end
            default:
                next_s.txSt = PQA_IDLE;
        endcase

        next_s.irq = |((next_s.stat1 & next_s.mask1) |
                       (next_s.stat2 & next_s.mask2));
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s <= '0;
            s.rate <= `PQA_RST_RATE;
            s.afull <= `PQA_RST_AFULL;
            s.pthr <= `PQA_RST_PTHR;
            s.opctl2 <= `PQA_RST_ZERO;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rdData = s.rdData;
    assign txPin = s.txPin;
    assign txEnable = s.txEnable;
    assign irq = s.irq;
    // modem fields straight from the setting registers
    assign modem = {s.filt,
                    s.modemRegs[1][7:5], s.modemRegs[0],
                    s.modemRegs[1][3:0], s.modemRegs[2], s.modemRegs[3],
                    s.modemRegs[4][2:0], s.modemRegs[5]};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_invSticky;
        invalidPulse |=> s.stat2[`PQA_BIT_INVALID];
    endproperty
    a_invSticky: assert property (p_invSticky)
        else $error("invalid preamble not latched in status");

    property p_invIrq;
        (invalidPulse && s.mask2[`PQA_BIT_INVALID]) |=> irq;
    endproperty
    a_invIrq: assert property (p_invIrq)
        else $error("unmasked invalid preamble gave no interrupt");

    property p_resend;
        (s.txSt == PQA_IDLE && s.opctl1[`PQA_BIT_TXREQ] && !s.newLoaded
         && s.canResend && !bus.wr) |=>
            (s.txSt == PQA_TX && s.rdPtr == $past(s.startPtr));
    endproperty
    a_resend: assert property (p_resend)
        else $error("last packet not rewound for resend");

    property p_stream;
        (bus.wr && bus.addr == `PQA_ADDR_FIFO && s.txSt == PQA_TX &&
         fill != `PQA_FIFO_FULL) |=> !s.canResend;
    endproperty
    a_stream: assert property (p_stream)
        else $error("streamed packet still marked for resend");

    property p_autoStart;
        (s.txSt == PQA_IDLE && s.opctl2[`PQA_BIT_AUTOTX] &&
         fill >= s.afull) |=> txEnable;
    endproperty
    a_autoStart: assert property (p_autoStart)
        else $error("almost full FIFO did not start transmit");

    property p_autoStop;
        (s.txSt == PQA_TX && s.bitTick && s.bitIdx == 3'h0 &&
         s.rdPtr == s.wrPtr) |=> (!txEnable && s.txSt == PQA_IDLE);
    endproperty
    a_autoStop: assert property (p_autoStop)
        else $error("empty FIFO did not return to idle");

    property p_filter;
        (bus.wr && bus.addr == `PQA_ADDR_FILT) |=>
            (modem.filterSetSelect == $past(bus.wrData[3:0]) &&
             modem.decimateByThreeSkip == $past(bus.wrData[7]));
    endproperty
    a_filter: assert property (p_filter)
        else $error("filter selection not taken from register");

    property p_ratio;
        (bus.wr && bus.addr == `PQA_ADDR_MODEM_LO) |=>
            modem.oversamplingRatio[7:0] == $past(bus.wrData);
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("oversampling ratio not taken from register");

    property p_readData;
        !$past(bus.rd) |-> rdData == 8'h00;
    endproperty
    a_readData: assert property (p_readData)
        else $error("read data shown without a read");

    property p_irqLevel;
        irq == |((s.stat1 & s.mask1) | (s.stat2 & s.mask2));
    endproperty
    a_irqLevel: assert property (p_irqLevel)
        else $error("interrupt level differs from masked status");

    property p_statClear;
        (bus.rd && bus.addr == `PQA_ADDR_STAT2 && !validPulse &&
         !invalidPulse) |=> s.stat2 == 8'h00;
    endproperty
    a_statClear: assert property (p_statClear)
        else $error("status not cleared by its read");

    property p_idlePin;
        !txEnable |-> !txPin;
    endproperty
    a_idlePin: assert property (p_idlePin)
        else $error("transmit pin active outside transmit");

    property p_startFlag;
        (s.txSt == PQA_IDLE && next_s.txSt == PQA_TX) |=>
            (txEnable && s.stat1[`PQA_BIT_TXSTART]);
    endproperty
    a_startFlag: assert property (p_startFlag)
        else $error("transmit start not flagged");

    c_autoTx: cover property (s.opctl2[`PQA_BIT_AUTOTX] && txEnable);
    c_resend: cover property (s.txSt == PQA_IDLE &&
        s.opctl1[`PQA_BIT_TXREQ] && s.canResend && !s.newLoaded);
    c_irq: cover property (irq);
endmodule // pqa_auto_tx_framer

// [pqa_far_radio.sv]
`timescale 1ns/100ps
module pqa_far_radio #(
    parameter int BIT_CYCLES = 4,
    parameter int PRE_BYTES  = 4
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // control from the bench
    input  wire logic sendPreamble,
    // air side
    output logic      rxPin,
    output logic      preambleDone
);
    int cyc;
    int bits;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cyc <= 0;
            bits <= 0;
            rxPin <= 1'b0;
        end
        else if (!sendPreamble)
        begin
            // no carrier: line changes every cycle, so the receive filter never sees two equal stages and keeps its last level
            cyc <= 0;
            bits <= 0;
            rxPin <= ~rxPin;
        end
        else if (cyc == BIT_CYCLES - 1)
        begin
            // alternating preamble, one bit per bit time
            cyc <= 0;
            bits <= bits + 1;
            rxPin <= ~rxPin;
        end
        else
        begin
            cyc <= cyc + 1;
        end
    end

    // preamble long enough for the fixed blanking time
    assign preambleDone = (bits >= PRE_BYTES * 8);
endmodule // pqa_far_radio

// [pqa_map.svh]
`ifndef PQA_MAP_SVH
`define PQA_MAP_SVH
// What this block does
// - flag invalid channel on first preamble error
// - both preamble flags readable in status registers
// - invalid preamble raises an interrupt event
// - invalid flag blanked sixteen bits after enable
// - transmit request without new data resends packet
// - resend only for packets held whole
// - automatic transmit starts at almost full level
// - automatic transmit returns idle when empty
// - channel filter selectable 620 to 2.6 kHz
// - modem settings come from registers 1C and 20-25
// - preamble threshold counts in four-bit units
// - after false detect, preamble search resumes
`define PQA_ADDR_STAT1     8'h03
`define PQA_ADDR_STAT2     8'h04
`define PQA_ADDR_MASK1     8'h05
`define PQA_ADDR_MASK2     8'h06
`define PQA_ADDR_OPCTL1    8'h07
`define PQA_ADDR_FILT      8'h1C
`define PQA_ADDR_MODEM_LO  8'h20
`define PQA_ADDR_MODEM_HI  8'h25
`define PQA_ADDR_PTHR      8'h35
`define PQA_ADDR_RATE_HI   8'h6E
`define PQA_ADDR_RATE_LO   8'h6F
`define PQA_ADDR_AFULL     8'h7C
`define PQA_ADDR_FIFO      8'h7F
`define PQA_ADDR_OPCTL2    8'h80
`define PQA_BIT_TXDONE     0
`define PQA_BIT_TXSTART    1
`define PQA_BIT_INVALID    0
`define PQA_BIT_VALID      1
`define PQA_BIT_RXON       0
`define PQA_BIT_TXREQ      1
`define PQA_BIT_TXCLR      0
`define PQA_BIT_AUTOTX     3
`define PQA_FIFO_FULL      7'h40
`define PQA_BLANK_TB       5'h10
`define PQA_RST_ZERO       8'h00
`define PQA_RST_RATE       16'h0400
`define PQA_RST_AFULL      7'h37
`define PQA_RST_PTHR       8'h20
`endif

// [pqa_pkg.sv]
package pqa_pkg;
    typedef enum logic {PQA_IDLE, PQA_TX} pqa_txst_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wr;
        logic       rd;
    } pqa_bus_t;
    typedef struct packed {
        logic        decimateByThreeSkip;
        logic [2:0]  decimationExponent;
        logic [3:0]  filterSetSelect;
        logic [10:0] oversamplingRatio;
        logic [19:0] ncoOffset;
        logic [10:0] clockRecoveryGain;
    } pqa_modem_t;
    typedef struct packed {
        logic       rxOnPrev;
        logic [4:0] blankCnt;
        logic [7:0] runCnt;
        logic       lastBit;
        logic       found;
        logic       validPulse;
        logic       invalidPulse;
    } pqa_pre_t;
    typedef struct packed {
        logic [63:0][7:0] mem;
        logic [6:0]       wrPtr;
        logic [6:0]       rdPtr;
        logic [6:0]       startPtr;
        logic             newLoaded;
        logic             canResend;
        pqa_txst_t        txSt;
        logic [7:0]       shift;
        logic [2:0]       bitIdx;
        logic [15:0]      bitCnt;
        logic             bitTick;
        logic [2:0]       sync;
        logic             rxLevel;
        logic [7:0]       stat1;
        logic [7:0]       stat2;
        logic [7:0]       mask1;
        logic [7:0]       mask2;
        logic [7:0]       opctl1;
        logic [7:0]       opctl2;
        logic [7:0]       filt;
        logic [5:0][7:0]  modemRegs;
        logic [7:0]       pthr;
        logic [15:0]      rate;
        logic [6:0]       afull;
        logic [7:0]       rdData;
        logic             irq;
        logic             txPin;
        logic             txEnable;
    } pqa_top_t;
endpackage

// [pqa_preamble_qualifier.sv]
`timescale 1ns/100ps
`include "pqa_map.svh"
module pqa_preamble_qualifier
    import pqa_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_b,
    // bit stream
    input  wire logic       bitTick,
    input  wire logic       rxLevel,
    input  wire logic       rxOn,
    input  wire logic [4:0] threshold,
    // detector events
    output logic            validPulse,
    output logic            invalidPulse
);
    pqa_pre_t s;
    pqa_pre_t next_s;
    logic [4:0] onTicks;

    always_comb
    begin
        next_s = s;
        next_s.validPulse = 1'b0;
        next_s.invalidPulse = 1'b0;
        next_s.rxOnPrev = rxOn;
        if (!rxOn)
        begin
            next_s.blankCnt = 5'h00;
            next_s.runCnt = 8'h00;
            next_s.found = 1'b0;
        end
        else if (!s.rxOnPrev)
        begin
            next_s.blankCnt = `PQA_BLANK_TB;
            next_s.runCnt = 8'h00;
            next_s.found = 1'b0;
        end
        else if (bitTick)
        begin
            next_s.lastBit = rxLevel;
            if (s.blankCnt != 5'h00)
                next_s.blankCnt = 5'(s.blankCnt - 5'h01);
            else if (rxLevel == s.lastBit)
            begin
                // broken alternation: restart the search
                next_s.runCnt = 8'h00;
                next_s.found = 1'b0;
                next_s.invalidPulse = !s.found;
            end
            else
            begin
                if (s.runCnt != 8'hFF)
                    next_s.runCnt = 8'(s.runCnt + 8'h01);
                if (!s.found && 8'(s.runCnt + 8'h01) >=
                    {1'b0, threshold, 2'b00})
                begin
                    next_s.found = 1'b1;
                    next_s.validPulse = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= next_s;
    end

    assign validPulse = s.validPulse;
    assign invalidPulse = s.invalidPulse;

    // bit ticks seen since receive was enabled, for checking only
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            onTicks <= 5'h00;
        else if (!rxOn)
            onTicks <= 5'h00;
        else if (bitTick && onTicks != 5'h1F)
            onTicks <= 5'(onTicks + 5'h01);
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_blank;
        invalidPulse |-> onTicks >= 5'h11;
    endproperty
    a_blank: assert property (p_blank)
        else $error("invalid flag inside blanking interval");

    property p_earlyInvalid;
        (bitTick && rxOn && s.rxOnPrev && s.blankCnt == 5'h00 &&
         rxLevel == s.lastBit && !s.found) |=> invalidPulse;
    endproperty
    a_earlyInvalid: assert property (p_earlyInvalid)
        else $error("preamble error did not flag invalid channel");

    property p_threshold;
        validPulse |-> s.runCnt >= {1'b0, $past(threshold), 2'b00};
    endproperty
    a_threshold: assert property (p_threshold)
        else $error("preamble found below threshold length");

    property p_resume;
        (bitTick && rxOn && s.rxOnPrev && s.found && s.blankCnt == 5'h00
         && rxLevel == s.lastBit) |=> (!s.found && s.runCnt == 8'h00);
    endproperty
    a_resume: assert property (p_resume)
        else $error("search did not resume after false detect");

    c_valid: cover property (validPulse);
    c_invalid: cover property (invalidPulse);
endmodule // pqa_preamble_qualifier

// [tb_preamble_qualify_auto_tx.sv]
`timescale 1ns/100ps
`include "pqa_map.svh"
module tb_preamble_qualify_auto_tx;
    import pqa_pkg::*;
    localparam logic [7:0] RST_A [6] = '{8'h6E, 8'h6F, 8'h7C, 8'h35, 8'h80,
                                        8'h55};
    localparam logic [7:0] RST_V [6] = '{8'h04, 8'h00, 8'h37, 8'h20, 8'h00,
                                        8'h00};
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    pqa_bus_t    bus = '0;
    logic [7:0]  rdData;
    logic        rxPin;
    logic        txPin;
    logic        txEnable;
    logic        irq;
    logic        farMode = 1'b0;
    logic        farDone;
    pqa_modem_t  modem;
    int          fail_count = 0;
    int          num_checks = 0;
    logic [31:0] seed = 32'h0000_5468;

    always #4 clock = ~clock;

    pqa_auto_tx_framer i_pqa_auto_tx_framer (
        .clock    (clock),
        .rst_b    (rst_b),
        .bus      (bus),
        .rdData   (rdData),
        .rxPin    (rxPin),
        .txPin    (txPin),
        .txEnable (txEnable),
        .modem    (modem),
        .irq      (irq)
    );

    pqa_far_radio #(.BIT_CYCLES(4), .PRE_BYTES(4)) i_pqa_far_radio (
        .clock        (clock),
        .rst_b        (rst_b),
        .sendPreamble (farMode),
        .rxPin        (rxPin),
        .preambleDone (farDone)
    );

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(string what, logic [63:0] e, logic [63:0] got);
        num_checks++;
        if (got !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask

    // bus tasks start and end just after a rising edge
    task automatic wr(logic [7:0] a, logic [7:0] d);
        bus.addr <= a;
        bus.wrData <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
        @(posedge clock);
    endtask

    // host-chosen filter code must show on the modem fields
    task automatic hostFilt(logic [7:0] c);
        wr(`PQA_ADDR_FILT, c);
        #1;
        cmp("filter fields", c, {modem.decimateByThreeSkip,
            modem.decimationExponent, modem.filterSetSelect});
        @(posedge clock);
    endtask

    task automatic chkRd(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
        logic [7:0] d;
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1;
        d = rdData;
        cmp($sformatf("register %h", a), e & m, d & m);
        @(posedge clock);
    endtask

    task automatic chkLvl(ref logic s, input logic e, input string n);
        #1;
        cmp(n, e, s);
        @(posedge clock);
    endtask

    task automatic waitLvl(ref logic s, input logic e, input int lim);
        int n;
        n = 0;
        #1;
        while (s !== e && n < lim)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        if (s !== e)
        begin
            fail_count++;
            $display("Error wait bound used up");
            conclude();
        end
        @(posedge clock);
    endtask

    // record the frame and pick bits in mid bit time
    task automatic txRun(logic [15:0] e);
        logic q[$];
        int   i;
        waitLvl(txEnable, 1'b1, 20);
        repeat (300)
        begin
            @(posedge clock);
            #1;
            if (txEnable !== 1'b1)
                break;
            q.push_back(txPin);
        end
        if (txEnable === 1'b1)
        begin
            fail_count++;
            $display("Error txEnable expected 0 seen 1");
            conclude();
        end
        i = 0;
        while (i < q.size() && q[i] !== 1'b1)
            i++;
        for (int k = 0; k < 16; k++)
            cmp("txPin bit", e[15-k],
                (i + k*4 + 2 < q.size()) ? q[i + k*4 + 2] : 1'bx);
        cmp("frame cycles", 1, q.size() >= 60 && q.size() <= 72);
        @(posedge clock);
    endtask

    initial
    begin
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] f;
        logic [7:0] m [6];
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        foreach (RST_A[j])
            chkRd(RST_A[j], RST_V[j]);
        // four clocks per bit; let the reset-rate bit time run out first
        wr(`PQA_ADDR_RATE_HI, 8'h00);
        wr(`PQA_ADDR_RATE_LO, 8'h04);
        repeat (1024) @(posedge clock);
        f = rnd();
        wr(`PQA_ADDR_FILT, f);
        for (int j = 0; j < 6; j++)
        begin
            m[j] = rnd();
            wr(8'(8'h20 + j), m[j]);
        end
        #1;
        cmp("modem", {f, m[1][7:5], m[0], m[1][3:0], m[2], m[3], m[4][2:0],
            m[5]}, modem);
        @(posedge clock);
        chkRd(`PQA_ADDR_FILT, f);
        // host sizing in kHz: 2.4 kb/s, 4.8 dev: index 4, 10.8 -> 11.5
        hostFilt(8'h33);
        // 10 kb/s, 2 dev: index 0.4, 12 -> 12.1
        hostFilt(8'h34);
        // 60 offset beyond half the band: AFC on, 120 -> 127.9
        hostFilt(8'h06);
        wr(`PQA_ADDR_MASK1, 8'h01);
        b0 = rnd() | 8'h80;
        b1 = rnd();
        wr(`PQA_ADDR_FIFO, b0);
        wr(`PQA_ADDR_FIFO, b1);
        wr(`PQA_ADDR_OPCTL1, 8'h02);
        txRun({b0, b1});
        chkLvl(irq, 1'b1, "irq");
        chkRd(`PQA_ADDR_STAT1, 8'h03);
        chkLvl(irq, 1'b0, "irq");
        chkRd(`PQA_ADDR_STAT1, 8'h00);
        // request again with nothing new loaded
        wr(`PQA_ADDR_OPCTL1, 8'h02);
        txRun({b0, b1});
        chkRd(`PQA_ADDR_OPCTL1, 8'h00);
        chkRd(`PQA_ADDR_STAT1, 8'h03);
        wr(`PQA_ADDR_AFULL, 8'h02);
        wr(`PQA_ADDR_OPCTL2, 8'h08);
        b0 = rnd() | 8'h80;
        b1 = rnd();
        wr(`PQA_ADDR_FIFO, b0);
        chkLvl(txEnable, 1'b0, "txEnable below level");
        wr(`PQA_ADDR_FIFO, b1);
        txRun({b0, b1});
        chkRd(`PQA_ADDR_STAT1, 8'h03);
        wr(`PQA_ADDR_OPCTL2, 8'h00);
        wr(`PQA_ADDR_PTHR, 8'h10);
        // no antenna diversity here, so the invalid event stays unmasked
        wr(`PQA_ADDR_MASK2, 8'h03);
        wr(`PQA_ADDR_OPCTL1, 8'h01);
        repeat (40) @(posedge clock);
        chkRd(`PQA_ADDR_STAT2, 8'h00);
        chkLvl(irq, 1'b0, "irq in blanking");
        repeat (100) @(posedge clock);
        chkLvl(irq, 1'b1, "irq invalid");
        chkRd(`PQA_ADDR_STAT2, 8'h01);
        farMode <= 1'b1;
        waitLvl(farDone, 1'b1, 400);
        chkRd(`PQA_ADDR_STAT2, 8'h02, 8'h02);
        farMode <= 1'b0;
        conclude();
    end
endmodule // tb_preamble_qualify_auto_tx
